// ### rtl/sbg_pkg.sv
// shared constants and types for the serial baud rate generator
// assumes one core clock and an apb slave port with 32-bit data
package sbg_pkg;
  localparam int unsigned AW = 5;
  // register byte addresses
  localparam logic [AW-1:0] ADDR_BAUD_CTRL = 5'h00;
  localparam logic [AW-1:0] ADDR_RX_CTRL   = 5'h04;
  localparam logic [AW-1:0] ADDR_DIV_LO    = 5'h08;
  localparam logic [AW-1:0] ADDR_DIV_HI    = 5'h0c;
  localparam logic [AW-1:0] ADDR_TX_CTRL   = 5'h10;
  // baud_control fields
  localparam int unsigned BC_RX_IDLE = 6;
  localparam int unsigned BC_CLK_POL = 4;
  localparam int unsigned BC_WIDE    = 3;
  localparam logic [7:0]  BC_WR_MASK = 8'h1b;
  // receive_status_control fields
  localparam int unsigned RC_PORT_EN = 7;
  localparam logic [7:0]  RC_WR_MASK = 8'hf8;
  // transmit_status_control fields
  localparam int unsigned TC_MASTER  = 7;
  localparam int unsigned TC_SYNC    = 4;
  localparam int unsigned TC_HSPD    = 2;
  localparam int unsigned TC_SH_EMPTY = 1;
  localparam logic [7:0]  TC_WR_MASK = 8'hfd;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  // divide factors as powers of two: 64, 16, 4
  localparam logic [2:0]  SHIFT_64 = 3'h6;
  localparam logic [2:0]  SHIFT_16 = 3'h4;
  localparam logic [2:0]  SHIFT_4  = 3'h2;
  localparam int unsigned PER_W    = 23;

  typedef struct packed {
    logic port_en;
    logic sync;
    logic master;
    logic wide;
    logic hspd;
    logic clk_pol;
  } sbg_cfg_t;
endpackage : sbg_pkg

// ### rtl/sbg_baud_gen.sv
// baud rate timer with apb register file and serial clock pin logic
// assumes apb master on CORE_CLK, receiver idle and shifter empty from same-clock logic
//
// What this block does
// - the timer serves async and sync modes, 8 bits wide by default and 16 bits with the width bit set.
// - the timer runs freely with its period set by the divisor n from the two divisor bytes.
// - in async mode the multiplier follows high speed and width bits; in sync mode high speed is ignored.
// - any write to either divisor byte clears the timer at once.
// - async, 8-bit, low speed gives one tick every 64*(n+1) clocks.
// - async, 16-bit, low speed gives one tick every 16*(n+1) clocks.
// - sync, 8-bit gives one tick every 4*(n+1) clocks whatever the high speed bit.
// - n is the high and low divisor bytes taken together as one pair in 16-bit width; 8-bit width uses the low byte alone.
// - width bit one selects 16-bit timer, zero selects 8-bit.
// - receiver idle flag reads one while idle and zero while receiving.
// - in sync master mode the serial clock comes from the timer, in slave mode from outside.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module sbg_baud_gen (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [4:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_IDLE,
  input  wire logic        TX_SHIFT_EMPTY,
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE_N,
  output logic             SYNC_CLK,
  output logic             BAUD_TICK
);
  logic [7:0]  baud_ctrl_q;
  logic [7:0]  rx_ctrl_q;
  logic [7:0]  div_lo_q;
  logic [7:0]  div_hi_q;
  logic [7:0]  tx_ctrl_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic [5:0]  pre_q;
  logic [15:0] cnt_q;
  logic        tick_q;
  logic        sck_q;
  logic        ext_s1_q;
  logic        ext_s2_q;

  // bus decode
  wire setup    = PSEL & ~PENABLE;
  wire wr_acc   = PSEL & PENABLE & PREADY & PWRITE;
  wire hit_bc   = PADDR == sbg_pkg::ADDR_BAUD_CTRL;
  wire hit_rc   = PADDR == sbg_pkg::ADDR_RX_CTRL;
  wire hit_lo   = PADDR == sbg_pkg::ADDR_DIV_LO;
  wire hit_hi   = PADDR == sbg_pkg::ADDR_DIV_HI;
  wire hit_tc   = PADDR == sbg_pkg::ADDR_TX_CTRL;
  wire mapped   = hit_bc | hit_rc | hit_lo | hit_hi | hit_tc;
  wire div_wr   = wr_acc & (hit_lo | hit_hi);
  wire [7:0] wb = PWDATA[7:0];

  sbg_pkg::sbg_cfg_t cfg;
  assign cfg = '{
    port_en: rx_ctrl_q[sbg_pkg::RC_PORT_EN],
    sync:    tx_ctrl_q[sbg_pkg::TC_SYNC],
    master:  tx_ctrl_q[sbg_pkg::TC_MASTER],
    wide:    baud_ctrl_q[sbg_pkg::BC_WIDE],
    hspd:    tx_ctrl_q[sbg_pkg::TC_HSPD],
    clk_pol: baud_ctrl_q[sbg_pkg::BC_CLK_POL]
  };

  // readback; status bits reflect live state
  wire [7:0] bc_rd = (baud_ctrl_q & sbg_pkg::BC_WR_MASK)
                   | (8'(RX_IDLE) << sbg_pkg::BC_RX_IDLE);
  wire [7:0] tc_rd = (tx_ctrl_q & sbg_pkg::TC_WR_MASK)
                   | (8'(TX_SHIFT_EMPTY) << sbg_pkg::TC_SH_EMPTY);
  wire [7:0] rd_byte = hit_bc ? bc_rd
                     : hit_rc ? rx_ctrl_q
                     : hit_lo ? div_lo_q
                     : hit_hi ? div_hi_q
                     : hit_tc ? tc_rd : 8'h00;

  // one wait-free access phase; read data captured in setup
  assign PREADY  = 1'b1;
  assign PRDATA  = rdata_q;
  assign PSLVERR = PSEL & PENABLE & err_q;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= {24'h0, rd_byte};
      err_q   <= ~mapped;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      baud_ctrl_q <= sbg_pkg::REG_RESET;
      rx_ctrl_q   <= sbg_pkg::REG_RESET;
      div_lo_q    <= sbg_pkg::REG_RESET;
      div_hi_q    <= sbg_pkg::REG_RESET;
      tx_ctrl_q   <= sbg_pkg::REG_RESET;
    end else if (wr_acc) begin
      if (hit_bc) baud_ctrl_q <= wb & sbg_pkg::BC_WR_MASK;
      if (hit_rc) rx_ctrl_q   <= wb & sbg_pkg::RC_WR_MASK;
      if (hit_lo) div_lo_q    <= wb;
      if (hit_hi) div_hi_q    <= wb;
      if (hit_tc) tx_ctrl_q   <= wb & sbg_pkg::TC_WR_MASK;
    end
  end

  // divisor pair, high byte dropped in 8-bit width
  wire [15:0] n_eff = cfg.wide ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};

  // factor select; sync ignores high speed
  wire [2:0] shift = cfg.sync ? sbg_pkg::SHIFT_4
                   : (cfg.wide & cfg.hspd) ? sbg_pkg::SHIFT_4
                   : (cfg.wide | cfg.hspd) ? sbg_pkg::SHIFT_16
                   : sbg_pkg::SHIFT_64;
  wire [5:0] pre_max  = 6'((7'h01 << shift) - 7'h01);
  wire       pre_wrap = pre_q >= pre_max;
  // >= keeps the timer sane when width shrinks n below the count
  wire       cnt_end  = cnt_q >= n_eff;
  wire       tick_d   = cfg.port_en & pre_wrap & cnt_end;
  wire       mid_d    = cfg.port_en & (pre_q == (pre_max >> 1)) & cnt_end;

  // free running timer, cleared by divisor write or port disable
  always_ff @(posedge CORE_CLK) begin
    if (SRST | ~cfg.port_en | div_wr) begin
      pre_q <= 6'h00;
      cnt_q <= 16'h0000;
    end else if (pre_wrap) begin
      pre_q <= 6'h00;
      cnt_q <= cnt_end ? 16'h0000 : cnt_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) tick_q <= 1'b0;
    else      tick_q <= tick_d & ~div_wr;
  end
  assign BAUD_TICK = tick_q;

  // master clock: low at bit boundary, high halfway through the last prescale round of the period
  wire is_master = cfg.sync & cfg.master & cfg.port_en;
  always_ff @(posedge CORE_CLK) begin
    if (SRST | ~is_master) sck_q <= 1'b0;
    else if (tick_d)       sck_q <= 1'b0;
    else if (mid_d)        sck_q <= 1'b1;
  end

  // slave clock from pin, two stages before use
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= SCK_IN;
      ext_s2_q <= ext_s1_q;
    end
  end

  assign SCK_OUT  = sck_q ^ cfg.clk_pol;
  assign SCK_OE_N = ~is_master;
  assign SYNC_CLK = is_master ? sck_q : ext_s2_q;

  // helper: cycles since last tick, any register write or port disable, for period checks
  logic [sbg_pkg::PER_W-1:0] per_q;
  logic                      per_ok_q;
  wire any_wr = wr_acc;
  always_ff @(posedge CORE_CLK) begin
    if (SRST | any_wr | ~cfg.port_en) begin
      per_q    <= '0;
      per_ok_q <= 1'b0;
    end else if (tick_q) begin
      per_q    <= 23'h000001;
      per_ok_q <= 1'b1;
    end else begin
      per_q    <= per_q + 23'h000001;
    end
  end
  wire [sbg_pkg::PER_W-1:0] per_exp = ({7'h00, n_eff} + 23'h000001) << shift;

  // helper: set by a divisor write, dropped by any other write, so the first tick is judged alone
  logic from_div_q;
  always_ff @(posedge CORE_CLK) begin
    if (SRST | (any_wr & ~div_wr) | ~cfg.port_en) begin
      from_div_q <= 1'b0;
    end else if (div_wr) begin
      from_div_q <= 1'b1;
    end else if (tick_q) begin
      from_div_q <= 1'b0;
    end
  end

  tick_period_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    tick_q && per_ok_q && $stable(n_eff) && $stable(shift) |-> per_q == per_exp)
    else $error("tick period differs from factor times n plus one");

  div_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    div_wr |=> pre_q == 6'h00 && cnt_q == 16'h0000 && !tick_q)
    else $error("divisor write did not clear the timer");

  slow_narrow_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.sync && !cfg.wide && !cfg.hspd |-> shift == sbg_pkg::SHIFT_64)
    else $error("async 8-bit low speed factor is not 64");

  slow_wide_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.sync && cfg.wide && !cfg.hspd |-> shift == sbg_pkg::SHIFT_16)
    else $error("async 16-bit low speed factor is not 16");

  sync_factor_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.sync |-> shift == sbg_pkg::SHIFT_4)
    else $error("sync factor is not 4");

  fast_async_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.sync && cfg.hspd |-> shift == (cfg.wide ? sbg_pkg::SHIFT_4 : sbg_pkg::SHIFT_16))
    else $error("high speed async factor wrong");

  narrow_width_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.wide |-> n_eff[15:8] == 8'h00 && n_eff[7:0] == div_lo_q)
    else $error("8-bit width uses high divisor byte");

  idle_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    setup && hit_bc |=> rdata_q[sbg_pkg::BC_RX_IDLE] == $past(RX_IDLE))
    else $error("receiver idle flag read wrong");

  master_clk_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    is_master && tick_d ##1 is_master |-> !sck_q && !SCK_OE_N && SYNC_CLK == sck_q)
    else $error("master clock not driven from timer");

  pair_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.wide |-> n_eff == {div_hi_q, div_lo_q})
    else $error("divisor pair not combined");

  first_tick_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    tick_q && from_div_q |-> per_q == per_exp)
    else $error("first tick after divisor write off its period");

  // timer steps, edge by edge, then clock pins, divisor byte access and factor select
  tick_gap_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    tick_q |=> !tick_q [*3])
    else $error("baud tick closer than the shortest period");

  tick_off_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.port_en |=> !tick_q)
    else $error("baud tick while port disabled");

  timer_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.port_en |=> pre_q == 6'h00 && cnt_q == 16'h0000)
    else $error("timer not held clear while port disabled");

  prescale_step_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.port_en && !div_wr && !pre_wrap |=> pre_q == $past(pre_q) + 6'h01)
    else $error("prescaler did not step");

  count_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.port_en && !div_wr && !pre_wrap |=> cnt_q == $past(cnt_q))
    else $error("timer count moved inside a prescale step");

  count_step_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.port_en && !div_wr && pre_wrap && !cnt_end |=> pre_q == 6'h00 && cnt_q == $past(cnt_q) + 16'h0001)
    else $error("timer count did not advance");

  count_wrap_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.port_en && !div_wr && pre_wrap && cnt_end |=> pre_q == 6'h00 && cnt_q == 16'h0000 && tick_q)
    else $error("timer did not wrap with a tick");

  tick_cause_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    tick_q |-> $past(pre_wrap && cnt_end && cfg.port_en && !div_wr))
    else $error("baud tick without timer wrap");

  master_rise_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    is_master && mid_d && !tick_d ##1 is_master |-> sck_q)
    else $error("master clock did not rise mid period");

  master_idle_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !is_master |=> !sck_q)
    else $error("internal clock runs outside sync master mode");

  slave_sync_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !$past(SRST) && !$past(SRST, 2) && !is_master |-> SYNC_CLK == $past(SCK_IN, 2))
    else $error("slave clock not taken from pin");

  lo_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_acc && hit_lo |=> div_lo_q == $past(wb))
    else $error("low divisor byte write lost");

  hi_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_acc && hit_hi |=> div_hi_q == $past(wb))
    else $error("high divisor byte write lost");

  lo_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    setup && hit_lo |=> PRDATA == {24'h000000, $past(div_lo_q)})
    else $error("low divisor byte read wrong");

  hi_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    setup && hit_hi |=> PRDATA == {24'h000000, $past(div_hi_q)})
    else $error("high divisor byte read wrong");

  async_width_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.sync && $stable(cfg.sync) && $stable(cfg.hspd) && $changed(cfg.wide) |-> $changed(shift))
    else $error("async factor ignores width bit");

  async_speed_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !cfg.sync && $stable(cfg.sync) && $stable(cfg.wide) && $changed(cfg.hspd) |-> $changed(shift))
    else $error("async factor ignores high speed bit");

  sync_speed_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cfg.sync && $stable(cfg.sync) && $changed(cfg.hspd) |-> $stable(shift))
    else $error("sync factor follows high speed bit");
endmodule : sbg_baud_gen

// ### bench/serial_baud_rate_generator_bench.sv
// self-checking bench for the baud rate generator: register file over apb, tick spacing in every mode
// assumes the design answers apb with its own pready and pulses baud_tick for one cycle per period
`timescale 1ns/100ps
module serial_baud_rate_generator_bench;
  logic        core_clk, srst, psel, penable, pwrite, rx_idle, tx_shift_empty, sck_in;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic        pready, pslverr, sck_out, sck_oe_n, sync_clk, baud_tick, e;
  int          fails, checked, f, n, c, hi, lo;
  logic [7:0]  mdl [5];
  logic [7:0]  msk [5] = '{sbg_pkg::BC_WR_MASK, sbg_pkg::RC_WR_MASK, 8'hff, 8'hff, sbg_pkg::TC_WR_MASK};

  sbg_baud_gen u_sbg_baud_gen (.CORE_CLK(core_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_IDLE(rx_idle), .TX_SHIFT_EMPTY(tx_shift_empty), .SCK_IN(sck_in), .SCK_OUT(sck_out),
    .SCK_OE_N(sck_oe_n), .SYNC_CLK(sync_clk), .BAUD_TICK(baud_tick));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic close_out;
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one cycle gap before each setup keeps every drive right after an edge
  task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int i, input logic [31:0] wd);
    apb(1'b1, 5'(i * 4), wd, q, e);
    mdl[i] = wd[7:0] & msk[i];
    chk("wr_err", 32'h0, {31'h0, e});
  endtask : wr

  task automatic rd_all;
    logic [7:0] x;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 5'(i * 4), $urandom, q, e);
      x = mdl[i];
      if (i == 0) x[6] = rx_idle;
      if (i == 4) x[1] = tx_shift_empty;
      chk("rd_data", {24'h0, x}, q);
      chk("rd_err", 32'h0, {31'h0, e});
    end
  endtask : rd_all

  // counts edges until the tick flop is seen high
  task automatic to_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (baud_tick !== 1'b1 && cnt < 20000);
  endtask : to_tick

  initial begin
    void'($urandom(92));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'b1;
    rx_idle = 1'b1;
    tx_shift_empty = 1'b1;
    sck_in = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rd_all;
    apb(1'b1, 5'h14, $urandom, q, e);
    chk("bad_wr_err", 32'h1, {31'h0, e});
    apb(1'b0, 5'h14, $urandom, q, e);
    chk("bad_rd_err", 32'h1, {31'h0, e});
    chk("bad_rd_data", 32'h0, q);
    wr(1, $urandom | 32'h80);
    for (int m = 0; m < 8; m++) begin
      rx_idle <= 1'($urandom);
      tx_shift_empty <= 1'($urandom);
      sck_in <= 1'($urandom);
      d = $urandom;
      d[3] = m[1];
      wr(0, d);
      d = $urandom;
      d[7] = m[0];
      d[4] = m[2];
      d[2] = m[0];
      wr(4, d);
      hi = $urandom % 2;
      lo = $urandom % 4;
      d = $urandom;
      d[7:0] = 8'(hi);
      wr(3, d);
      repeat ($urandom % 40) @(posedge core_clk);
      d = $urandom;
      d[7:0] = 8'(lo);
      wr(2, d);
      // high byte only counts in the wide mode
      n = m[1] ? hi * 256 + lo : lo;
      f = m[2] ? 4 : (m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64));
      to_tick(c);
      chk("first_tick", f * (n + 1), c);
      to_tick(c);
      chk("tick_period", f * (n + 1), c);
      chk("sck_oe_n", {31'h0, !(m[2] && mdl[4][7])}, {31'h0, sck_oe_n});
      if (m[2] && !mdl[4][7]) chk("sync_clk", {31'h0, sck_in}, {31'h0, sync_clk});
      chk("sck_out", {31'h0, mdl[0][4]}, {31'h0, sck_out});
      if (m[2] && mdl[4][7]) chk("sync_clk", 32'h0, {31'h0, sync_clk});
      rd_all;
    end
    // quiet while the port is off, restart from zero on enable
    rx_idle <= 1'b1;
    wr(3, 32'h0);
    wr(2, 32'h0);
    wr(1, 32'h0);
    e = 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      #1;
      e = e | baud_tick;
    end
    chk("tick_off", 32'h0, {31'h0, e});
    wr(1, 32'h80);
    to_tick(c);
    chk("enable_tick", f, c);
    apb(1'b0, 5'h00, $urandom, q, e);
    chk("idle_first", 32'h1, {31'h0, q[6]});
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    chk("rst_tick", 32'h0, {31'h0, baud_tick});
    chk("rst_oe_n", 32'h1, {31'h0, sck_oe_n});
    chk("rst_sck_out", 32'h0, {31'h0, sck_out});
    rd_all;
    close_out;
  end

  initial begin
    #1800000;
    fails++;
    close_out;
  end
endmodule : serial_baud_rate_generator_bench
